// file: logic/cpld_block_params.svh
`ifndef CPLD_BLOCK_PARAMS_SVH
`define CPLD_BLOCK_PARAMS_SVH

// Sizes of one logic block and of the device
`define RM_WIDTH        36
`define LIT_WIDTH       72
`define TERM_COUNT      86
`define MC_COUNT        16
`define SLOT_COUNT      16
`define PIN_COUNT       8
`define DED_COUNT       5
`define EXT_WIDTH       35
`define POOL_WIDTH      64
`define SEL_WIDTH       6
`define TIDX_WIDTH      7
`define ADDR_WIDTH      11
`define DATA_WIDTH      32
`define TERM_WORD_BITS  24
`define TERM_WORDS      3
`define GCLK_COUNT      2
`define DEVICE_PINS     64

// Word offsets of the configuration port
`define SEL_BASE        11'h000
`define SEL_END         11'h024
`define MC_BASE         11'h040
`define MC_END          11'h050
`define CLK_CFG_ADDR    11'h050
`define STAT_ADDR       11'h051
`define PIN_ADDR        11'h052
`define TERM_BASE       11'h100
`define TERM_END        11'h258
`define SLOT_BASE       11'h400
`define SLOT_END        11'h500

// Field positions
`define CLK_SEL_BITS    2
`define SLOT_EN_BIT     7
`define MC_CFG_BITS     7

// Reset values
`define CLK_CFG_RESET   4'h4

`endif

// file: logic/cpld_block_pkg.sv
`include "cpld_block_params.svh"

package cpld_block_pkg;

    // Storage element behaviour of a macrocell
    typedef enum logic [1:0] {
        mode_comb  = 2'b00,
        mode_dff   = 2'b01,
        mode_tff   = 2'b10,
        mode_latch = 2'b11
    } mc_mode_type;

    // Per-macrocell configuration word
    typedef struct packed {
        logic        in_latch;
        logic        in_reg;
        logic        oe;
        logic        clk_sel;
        logic        invert;
        mc_mode_type mode;
    } mc_cfg_type;

    // One allocator slot: enable and product-term index
    typedef struct packed {
        logic                   en;
        logic [`TIDX_WIDTH-1:0] index;
    } slot_type;

    // Configuration port request
    typedef struct packed {
        logic [`ADDR_WIDTH-1:0] addr;
        logic [`DATA_WIDTH-1:0] wdata;
        logic                   write;
        logic                   read;
    } cfg_req_type;

    // Pin drive towards the pads
    typedef struct packed {
        logic [`PIN_COUNT-1:0] out;
        logic [`PIN_COUNT-1:0] oe;
    } pad_type;

    // Whole state of the logic block
    typedef struct packed {
        logic [`TERM_COUNT-1:0][`LIT_WIDTH-1:0]  term_mask;
        slot_type [`MC_COUNT-1:0][`SLOT_COUNT-1:0] slot;
        logic [`RM_WIDTH-1:0][`SEL_WIDTH-1:0]    sel;
        mc_cfg_type [`MC_COUNT-1:0]              mc_cfg;
        logic [3:0]                              clk_cfg;
        logic [`MC_COUNT-1:0]                    mc_q;
        logic [`PIN_COUNT-1:0]                   pin_meta;
        logic [`PIN_COUNT-1:0]                   pin_sync;
        logic [`DED_COUNT-1:0]                   ded_meta;
        logic [`DED_COUNT-1:0]                   ded_sync;
        logic [`GCLK_COUNT-1:0]                  clk_prev;
        pad_type                                 pad;
        logic [`PIN_COUNT-1:0]                   keep_io;
        logic [`DED_COUNT-1:0]                   keep_ded;
        logic [`DATA_WIDTH-1:0]                  rdata;
    } state_type;

endpackage

// file: logic/cpld_logic_block.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "cpld_block_params.svh"

// Operation
// - Array takes 36 routed signals, true and inverted, forming 86 product terms.
// - One block holds one array, one allocator and sixteen macrocells.
// - Allocator steers zero to sixteen terms to any macrocell of the block.
// - One product term may feed several macrocells at the same time.
// - Macrocell data input is the OR of its allocated terms, up to sixteen.
// - I/O macrocell has sum inversion and a bypassable register.
// - Register clock is one of two global clocks chosen by configuration.
// - Storage is combinatorial, D flip-flop, T flip-flop or transparent latch.
// - I/O macrocell register returns to routing matrix on its own feedback path.
// - Buried macrocell may register or latch the neighbouring I/O pin.
// - Buried macrocell output always goes to the routing matrix.
// - All inputs and feedbacks reach the array through the matrix, uniform delay; here pins and dedicated inputs pass two synchroniser stages, other blocks none.
// - One pin per macrocell pair, sixty-four pins over the device.
// - One dedicated input and four input-or-clock pins.
// - Every pin and dedicated input keeps its last level when undriven.
module cpld_logic_block (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        resetn,
    // Configuration port
    input  wire cpld_block_pkg::cfg_req_type cfg_req,
    output logic [`DATA_WIDTH-1:0]           cfg_rdata,
    // I/O pins of this block
    input  wire logic [`PIN_COUNT-1:0]       pin_in,
    output cpld_block_pkg::pad_type          pad,
    // Dedicated input and input-or-clock pins
    input  wire logic [`DED_COUNT-1:0]       ded_in,
    // Routing matrix towards and from the other blocks
    input  wire logic [`EXT_WIDTH-1:0]       ext_route,
    output logic [`MC_COUNT-1:0]             fb_out,
    // Bus-hold keeper levels
    output logic [`PIN_COUNT-1:0]            keep_io,
    output logic [`DED_COUNT-1:0]            keep_ded
);

    cpld_block_pkg::state_type   s;
    cpld_block_pkg::state_type   next_s;

    logic [`POOL_WIDTH-1:0]      pool;
    logic [`RM_WIDTH-1:0]        rm_in;
    logic [`LIT_WIDTH-1:0]       lit;
    logic [`TERM_COUNT-1:0]      pterm;
    logic [`GCLK_COUNT-1:0]      gclk_lvl;
    logic [`GCLK_COUNT-1:0]      gclk_edge;
    logic [`MC_COUNT-1:0]        sum_d;
    logic [`ADDR_WIDTH-1:0]      term_off;
    logic [`ADDR_WIDTH-1:0]      slot_off;
    logic [`ADDR_WIDTH-1:0]      sel_off;
    logic [`ADDR_WIDTH-1:0]      mc_off;
    logic                        in_term;
    logic                        in_slot;
    logic                        in_sel;
    logic                        in_mc;

    // Address decode of the configuration port
    assign term_off = cfg_req.addr - `TERM_BASE;
    assign slot_off = cfg_req.addr - `SLOT_BASE;
    assign sel_off  = cfg_req.addr - `SEL_BASE;
    assign mc_off   = cfg_req.addr - `MC_BASE;
    assign in_term  = (cfg_req.addr >= `TERM_BASE) && (cfg_req.addr < `TERM_END)
                      && (term_off[1:0] != 2'h3);
    assign in_slot  = (cfg_req.addr >= `SLOT_BASE) && (cfg_req.addr < `SLOT_END);
    assign in_sel   = (cfg_req.addr < `SEL_END);
    assign in_mc    = (cfg_req.addr >= `MC_BASE) && (cfg_req.addr < `MC_END);

    // Feedback, pins, dedicated inputs and other blocks form the matrix pool
    assign pool = {ext_route, s.ded_sync, s.pin_sync, s.mc_q};

    // Routing matrix selection, one selector per array input
    always_comb begin
        rm_in = '0;
        for (int i = 0; i < `RM_WIDTH; i++) begin
            rm_in[i] = pool[s.sel[i]];
        end
    end

    // True and complemented literals
    assign lit = {~rm_in, rm_in};

    // Product terms; an empty term reads low
    always_comb begin
        pterm = '0;
        for (int t = 0; t < `TERM_COUNT; t++) begin
            pterm[t] = (|s.term_mask[t]) & (&(lit | ~s.term_mask[t]));
        end
    end

    // Global clock selection from the four clock-capable pins
    always_comb begin
        gclk_lvl = '0;
        for (int g = 0; g < `GCLK_COUNT; g++) begin
            gclk_lvl[g] = s.ded_sync[1 + s.clk_cfg[g*`CLK_SEL_BITS +: `CLK_SEL_BITS]];
        end
    end
    assign gclk_edge = gclk_lvl & ~s.clk_prev;

    // Allocator: each macrocell ORs the terms its slots point at
    always_comb begin
        sum_d = '0;
        for (int m = 0; m < `MC_COUNT; m++) begin
            for (int k = 0; k < `SLOT_COUNT; k++) begin
                // Terms are shared by reading the same index from many slots
                if (s.slot[m][k].en && (s.slot[m][k].index < 7'(`TERM_COUNT))) begin
                    sum_d[m] = sum_d[m] | pterm[s.slot[m][k].index];
                end
            end
            sum_d[m] = sum_d[m] ^ s.mc_cfg[m].invert;
        end
    end

    // Next state: macrocells, pins, keepers and the configuration port
    always_comb begin
        next_s = s;
        next_s.clk_prev = gclk_lvl;

        // Two-stage synchronisers on all pins
        next_s.pin_meta = pin_in;
        next_s.pin_sync = s.pin_meta;
        next_s.ded_meta = ded_in;
        next_s.ded_sync = s.ded_meta;

        // Macrocell storage elements
        for (int m = 0; m < `MC_COUNT; m++) begin
            if (m[0] && s.mc_cfg[m].in_reg) begin
                // Buried cell capturing the neighbouring I/O pin
                if (s.mc_cfg[m].in_latch) begin
                    if (gclk_lvl[s.mc_cfg[m].clk_sel]) begin
                        next_s.mc_q[m] = s.pin_sync[m/2];
                    end
                end else if (gclk_edge[s.mc_cfg[m].clk_sel]) begin
                    next_s.mc_q[m] = s.pin_sync[m/2];
                end
            end else begin
                unique case (s.mc_cfg[m].mode)
                    cpld_block_pkg::mode_comb: begin
                        next_s.mc_q[m] = sum_d[m];
                    end
                    cpld_block_pkg::mode_dff: begin
                        if (gclk_edge[s.mc_cfg[m].clk_sel]) begin
                            next_s.mc_q[m] = sum_d[m];
                        end
                    end
                    cpld_block_pkg::mode_tff: begin
                        if (gclk_edge[s.mc_cfg[m].clk_sel] && sum_d[m]) begin
                            next_s.mc_q[m] = ~s.mc_q[m];
                        end
                    end
                    cpld_block_pkg::mode_latch: begin
                        if (gclk_lvl[s.mc_cfg[m].clk_sel]) begin
                            next_s.mc_q[m] = sum_d[m];
                        end
                    end
                endcase
            end
        end

        // Even cells drive the pin of their pair; odd cells stay buried
        for (int p = 0; p < `PIN_COUNT; p++) begin
            next_s.pad.out[p] = s.mc_q[2*p];
            next_s.pad.oe[p]  = s.mc_cfg[2*p].oe;
            // Keeper follows our drive, else the last level seen on the pin
            next_s.keep_io[p] = s.pad.oe[p] ? s.pad.out[p] : s.pin_sync[p];
        end
        next_s.keep_ded = s.ded_sync;

        // Read data stand for one cycle only
        next_s.rdata = '0;
        if (cfg_req.read) begin
            if (in_sel) begin
                next_s.rdata = 32'(s.sel[sel_off[5:0]]);
            end else if (in_mc) begin
                next_s.rdata = 32'(s.mc_cfg[mc_off[3:0]]);
            end else if (cfg_req.addr == `CLK_CFG_ADDR) begin
                next_s.rdata = 32'(s.clk_cfg);
            end else if (cfg_req.addr == `STAT_ADDR) begin
                next_s.rdata = 32'(s.mc_q);
            end else if (cfg_req.addr == `PIN_ADDR) begin
                next_s.rdata = 32'({s.ded_sync, s.pin_sync});
            end else if (in_term) begin
                next_s.rdata = 32'(s.term_mask[term_off[9:2]]
                                   [term_off[1:0]*`TERM_WORD_BITS +: `TERM_WORD_BITS]);
            end else if (in_slot) begin
                next_s.rdata = 32'(s.slot[slot_off[7:4]][slot_off[3:0]]);
            end
        end

        // Configuration writes; unmapped addresses are ignored
        if (cfg_req.write) begin
            if (in_sel) begin
                next_s.sel[sel_off[5:0]] = cfg_req.wdata[`SEL_WIDTH-1:0];
            end else if (in_mc) begin
                next_s.mc_cfg[mc_off[3:0]] =
                    cpld_block_pkg::mc_cfg_type'(cfg_req.wdata[`MC_CFG_BITS-1:0]);
            end else if (cfg_req.addr == `CLK_CFG_ADDR) begin
                next_s.clk_cfg = cfg_req.wdata[3:0];
            end else if (in_term) begin
                next_s.term_mask[term_off[9:2]]
                    [term_off[1:0]*`TERM_WORD_BITS +: `TERM_WORD_BITS] =
                    cfg_req.wdata[`TERM_WORD_BITS-1:0];
            end else if (in_slot) begin
                next_s.slot[slot_off[7:4]][slot_off[3:0]] =
                    cpld_block_pkg::slot_type'(cfg_req.wdata[`SLOT_EN_BIT:0]);
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s         <= '0;
            s.clk_cfg <= `CLK_CFG_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign cfg_rdata = s.rdata;
    assign pad       = s.pad;
    assign fb_out    = s.mc_q;
    assign keep_io   = s.keep_io;
    assign keep_ded  = s.keep_ded;

endmodule

// file: test/board_pin_model.sv
`timescale 1ns/1ns

module board_pin_model (
    // Pads of the block and its keeper
    input  wire cpld_block_pkg::pad_type pad,
    input  wire logic [7:0]              keep_io,
    // Board drivers
    input  wire logic [7:0]              drv_en,
    input  wire logic [7:0]              drv_val,
    // Resolved pin levels
    output logic [7:0]                   pin_in
);
    // Block drive wins, then the board, else the weak keeper holds the wire
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            if (pad.oe[p]) begin
                pin_in[p] = pad.out[p];
            end else if (drv_en[p]) begin
                pin_in[p] = drv_val[p];
            end else begin
                pin_in[p] = keep_io[p];
            end
        end
    end
endmodule

// file: test/cpld_block_asserts.sv
`timescale 1ns/1ns
`include "cpld_block_params.svh"

module cpld_block_asserts (
    // Clock and reset
    input wire logic                        clock,
    input wire logic                        resetn,
    // Watched ports of the block
    input wire cpld_block_pkg::cfg_req_type cfg_req,
    input wire logic [`DATA_WIDTH-1:0]      cfg_rdata,
    input wire logic [`PIN_COUNT-1:0]       pin_in,
    input wire cpld_block_pkg::pad_type     pad,
    input wire logic [`DED_COUNT-1:0]       ded_in,
    input wire logic [`EXT_WIDTH-1:0]       ext_route,
    input wire logic [`MC_COUNT-1:0]        fb_out,
    input wire logic [`PIN_COUNT-1:0]       keep_io,
    input wire logic [`DED_COUNT-1:0]       keep_ded
);
    logic [`PIN_COUNT-1:0] fb_even;

    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // I/O cells are the even macrocells
    always_comb begin
        for (int p = 0; p < `PIN_COUNT; p++) begin
            fb_even[p] = fb_out[2*p];
        end
    end

    pad_follow_a: assert property ((pad.out & pad.oe) == ($past(fb_even) & pad.oe))
        else $error("pad level differs from its I/O cell");
    keep_drv_a: assert property ($stable(pad) |-> ((keep_io ^ pad.out) & pad.oe) == 8'h0)
        else $error("keeper lost the driven level");
    keep_pin_a: assert property (($stable(pin_in) && $stable(pad.oe))[*4]
        |-> ((keep_io ^ pin_in) & ~pad.oe) == 8'h0) else $error("keeper lost the pin level");
    keep_ded_a: assert property ($stable(ded_in)[*4] |-> keep_ded == ded_in)
        else $error("dedicated keeper wrong");
    fb_quiet_a: assert property ((!cfg_req.write && $stable(pin_in) && $stable(ded_in)
        && $stable(ext_route))[*6] |-> $stable(fb_out))
        else $error("feedback moved with quiet inputs");
    stat_fb_a: assert property (cfg_req.read && cfg_req.addr == `STAT_ADDR && $stable(fb_out)
        |=> cfg_rdata[15:0] == $past(fb_out)) else $error("status differs from feedback");
    oe_cause_a: assert property ($changed(pad.oe) |-> $past(cfg_req.write)
        || $past(cfg_req.write, 2) || $past(cfg_req.write, 3)) else $error("enable moved alone");
    rdata_idle_a: assert property (!cfg_req.read |=> cfg_rdata == 32'h0)
        else $error("read data without a read");

    // Main scenarios reached
    cover property (pad.oe != 8'h0);
    cover property ($rose(fb_out[1]));
    cover property ($fell(fb_out[3]));
    cover property ($rose(fb_out[9]));
endmodule

bind cpld_logic_block cpld_block_asserts i_cpld_block_asserts (
    .clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .pin_in(pin_in), .pad(pad), .ded_in(ded_in), .ext_route(ext_route),
    .fb_out(fb_out), .keep_io(keep_io), .keep_ded(keep_ded));

// file: test/cpld_logic_block_tb_top.sv
`timescale 1ns/1ns
`include "cpld_block_params.svh"

module cpld_logic_block_tb_top;
    logic                        clock = 1'b0;
    logic                        resetn = 1'b0;
    cpld_block_pkg::cfg_req_type cfg_req = '0;
    cpld_block_pkg::pad_type     pad;
    logic [31:0]                 cfg_rdata;
    logic [7:0]                  pin_in, keep_io, drv_en = 8'h02, drv_val = 8'h00;
    logic [4:0]                  ded_in = 5'h00;
    logic [34:0]                 ext_route = 35'h0;
    logic [4:0]                  keep_ded;
    logic [15:0]                 fb_out;
    logic [6:0]                  cell_cfg [8] = '{7'h10, 7'h01, 7'h00, 7'h0a,
                                                  7'h14, 7'h03, 7'h00, 7'h21};
    int                          error_cnt = 0;
    int                          checked = 0;

    // Clock of 100 ns
    always #50 clock = ~clock;

    // Block and board
    cpld_logic_block i_cpld_logic_block (.clock(clock), .resetn(resetn), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .pin_in(pin_in), .pad(pad), .ded_in(ded_in),
        .ext_route(ext_route), .fb_out(fb_out), .keep_io(keep_io), .keep_ded(keep_ded));
    board_pin_model i_board_pin_model (.pad(pad), .keep_io(keep_io), .drv_en(drv_en),
        .drv_val(drv_val), .pin_in(pin_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge clock);
        cfg_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        cfg_req.write <= 1'b0;
    endtask

    task automatic rd(input logic [10:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clock);
        cfg_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge clock);
        cfg_req.read <= 1'b0;
        #1 check(cfg_rdata & m, exp);
    endtask

    task automatic settle;
        repeat (6) @(posedge clock);
        #1;
    endtask

    // Slow pulse on an input-or-clock pin
    task automatic pulse(input int b);
        @(posedge clock) ded_in[b] <= 1'b1;
        repeat (4) @(posedge clock);
        ded_in[b] <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic test_regs;
        rd(`CLK_CFG_ADDR, 32'hf, 32'h4);
        rd(11'h053, 32'hffffffff, 32'h0);
        wr(`CLK_CFG_ADDR, 32'h6);
        rd(`CLK_CFG_ADDR, 32'hf, 32'h6);
        wr(`CLK_CFG_ADDR, 32'h4);
    endtask

    // Pin 1 feeds term 0; cell 0 fills all sixteen slots, only the last one with term 0
    task automatic setup;
        wr(`SEL_BASE, 32'h11);
        wr(`TERM_BASE, 32'h1);
        for (int k = 0; k < 16; k++) begin
            wr(`SLOT_BASE + 11'(k), (k == 15) ? 32'h80 : 32'h81);
        end
        for (int m = 0; m < 8; m++) begin
            wr(`MC_BASE + 11'(m), {25'h0, cell_cfg[m]});
            if (m inside {1, 3, 4, 5}) begin
                wr(`SLOT_BASE + 11'(16 * m), 32'h80);
            end
        end
    endtask

    task automatic test_comb;
        settle;
        check({pad.oe[2], pad.oe[0]}, 2'b11);
        check({pad.out[2], pad.out[0]}, 2'b10);
        @(posedge clock) drv_val[1] <= 1'b1;
        settle;
        check({pad.out[2], pad.out[0], fb_out[1]}, 3'b010);
    endtask

    task automatic test_clocked;
        pulse(1);
        check({fb_out[3], fb_out[1]}, 2'b01);
        rd(`STAT_ADDR, 32'ha, 32'h2);
        pulse(2);
        check(fb_out[3], 1'b1);
        pulse(2);
        check(fb_out[3], 1'b0);
        @(posedge clock) drv_val[1] <= 1'b0;
        pulse(2);
        check({fb_out[3], fb_out[1]}, 2'b01);
    endtask

    task automatic test_latch;
        @(posedge clock) ded_in[1] <= 1'b1;
        @(posedge clock) drv_val[1] <= 1'b1;
        settle;
        check(fb_out[5], 1'b1);
        check(keep_ded, 5'h02);
        @(posedge clock) drv_val[1] <= 1'b0;
        settle;
        check(fb_out[5], 1'b0);
        @(posedge clock) ded_in[1] <= 1'b0;
        settle;
        @(posedge clock) drv_val[1] <= 1'b1;
        settle;
        check(fb_out[5], 1'b0);
    endtask

    // Buried input register on pin 3, keeper hold, then clock 0 moved to pin 3
    task automatic test_inreg;
        @(posedge clock);
        drv_en <= 8'h0a;
        drv_val <= 8'h0a;
        pulse(1);
        check(fb_out[7], 1'b1);
        @(posedge clock) drv_en <= 8'h02;
        settle;
        check(keep_io[3], 1'b1);
        rd(`PIN_ADDR, 32'h8, 32'h8);
        wr(`CLK_CFG_ADDR, 32'h6);
        @(posedge clock);
        drv_en <= 8'h0a;
        drv_val <= 8'h02;
        pulse(1);
        check(fb_out[7], 1'b1);
        pulse(3);
        check(fb_out[7], 1'b0);
        // Input latch on pin 3: transparent while clock 0 is high
        wr(`MC_BASE + 11'h7, 32'h61);
        @(posedge clock) ded_in[3] <= 1'b1;
        @(posedge clock) drv_val <= 8'h0a;
        settle;
        check(fb_out[7], 1'b1);
        @(posedge clock) ded_in[3] <= 1'b0;
        settle;
        @(posedge clock) drv_val <= 8'h02;
        settle;
        check(fb_out[7], 1'b1);
    endtask

    // Other-block signal 0 reaches buried cell 9 through selector 1 and term 2
    task automatic test_route;
        wr(`SEL_BASE + 11'h1, 32'h1d);
        wr(`TERM_BASE + 11'h8, 32'h2);
        wr(`SLOT_BASE + 11'h90, 32'h82);
        @(posedge clock) ext_route[0] <= 1'b1;
        repeat (2) @(posedge clock);
        #1 check(fb_out[9], 1'b1);
        rd(`STAT_ADDR, 32'h200, 32'h200);
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        test_regs;
        setup;
        test_comb;
        test_clocked;
        test_latch;
        test_inreg;
        test_route;
        stop_test;
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        stop_test;
    end
endmodule
